// ### dcdac_channel.sv
// Far-side address register and upper channel control of one DMA channel.
// Assumes the packet mover acknowledges each packet with pkt_done and
// that handshake pins come from another clock domain.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] Far-side address drives the device bus address
// [R2] Step far address by size per packet
// [R3] Address bits above bus width stay zero
// [R4] Abort bit ends the transfer at once
// [R5] Go bit starts software-paced transfer
// [R6] Software sets handshake-disable before using go
// [R7] Packet width taken from size field
// [R8] Software programs only sizes 1, 2, 4
// [R9] Handshake-disable ignores request, terminate, done
// [R10] Step enable clear keeps address unchanged
// [R11] Run needs channel enable and engine activate
// [R12] Illegal size issues no bus transfer
module dcdac_channel #(
  parameter int ADDR_W = 32 // Width of the system bus address
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flow-control handshake pins
  input wire dcdac_pkg::dcdac_hs_t hs_in,
  // Far-side packet request and completion
  output dcdac_pkg::dcdac_bus_t far_bus,
  input wire logic pkt_done,
  // Transfer status
  output logic busy,
  output logic aborted
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DC_IDLE = 3'b001, // Waiting for a start
    DC_XFER = 3'b010, // Moving packets
    DC_WAIT = 3'b100  // Packet issued, awaiting completion
  } dcdac_state_t;
  localparam logic [31:0] ADDR_MASK = (ADDR_W >= 32) ? 32'hffff_ffff : ((32'h1 << ADDR_W) - 32'h1);
  dcdac_state_t state_ff; // Channel sequencer
  logic [31:0] far_addr_ff; // Far-side address register
  logic abort_ff; // Abort control bit
  logic go_ff; // Firmware kick bit
  logic [2:0] size_ff; // Packet byte size
  logic hs_dis_ff; // Handshake disable
  logic inc_far_ff; // Far address stepping
  logic chan_en_ff; // Channel enable
  logic engine_en_ff; // Engine activate
  dcdac_pkg::dcdac_hs_t hs_s1_ff; // First sync stage, read only by second
  dcdac_pkg::dcdac_hs_t hs_s2_ff; // Synchronised handshake
  dcdac_pkg::dcdac_bus_t bus_ff; // Far-side request
  logic aborted_ff; // Last transfer ended by abort
  logic run; // Channel may operate
  logic size_ok; // Size code legal
  logic hs_req; // Gated request
  logic hs_end; // Gated terminate or done
  logic [31:0] ctrl_rd; // Control readback
  logic [31:0] nxt_far_addr; // Stepped far address

  // Legal packet sizes are 1, 2 or 4 bytes
  function automatic logic size_legal(input logic [2:0] s);
    size_legal = (s == 3'h1) || (s == 3'h2) || (s == 3'h4);
  endfunction : size_legal

  assign run = chan_en_ff & engine_en_ff; // R11
  assign size_ok = size_legal(size_ff); // R12
  assign hs_req = hs_s2_ff.req & ~hs_dis_ff; // R9
  assign hs_end = (hs_s2_ff.term | hs_s2_ff.done) & ~hs_dis_ff; // R9
  assign nxt_far_addr = (far_addr_ff + {29'h0, size_ff}) & ADDR_MASK; // R2 R3

  // ----------------------------------------------------------------
  // Handshake synchroniser
  // ----------------------------------------------------------------
  // Two stages; pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs_s1_ff <= '0;
      hs_s2_ff <= '0;
    end else begin
      hs_s1_ff <= hs_in;
      hs_s2_ff <= hs_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Go and abort self-clear once acted upon so a single write is one request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      abort_ff <= 1'b0;
      go_ff <= 1'b0;
      size_ff <= dcdac_pkg::RST_SIZE;
      hs_dis_ff <= 1'b0;
      inc_far_ff <= 1'b0;
      chan_en_ff <= 1'b0;
      engine_en_ff <= 1'b0;
    end else begin
      // Clear consumed requests first; a write in the same cycle wins
      if (state_ff == DC_IDLE) begin
        abort_ff <= 1'b0;
      end
      if (state_ff != DC_IDLE) begin
        go_ff <= 1'b0;
      end
      if (reg_wr && reg_addr == dcdac_pkg::OFS_CONTROL) begin
        abort_ff <= reg_wdata[dcdac_pkg::POS_ABORT];
        go_ff <= reg_wdata[dcdac_pkg::POS_GO];
        size_ff <= reg_wdata[dcdac_pkg::POS_SIZE_LO +: 3];
        hs_dis_ff <= reg_wdata[dcdac_pkg::POS_HS_DIS];
        inc_far_ff <= reg_wdata[dcdac_pkg::POS_INC_FAR];
      end
      if (reg_wr && reg_addr == dcdac_pkg::OFS_CHAN_ACTIVATE) begin
        chan_en_ff <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == dcdac_pkg::OFS_ENGINE) begin
        engine_en_ff <= reg_wdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Far-side address register
  // ----------------------------------------------------------------
  // Hardware step and software write collide rarely; software wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      far_addr_ff <= dcdac_pkg::RST_FAR_ADDR;
    end else if (reg_wr && reg_addr == dcdac_pkg::OFS_FAR_ADDR) begin
      far_addr_ff <= reg_wdata & ADDR_MASK; // R3
    end else if (state_ff == DC_WAIT && pkt_done && inc_far_ff) begin
      far_addr_ff <= nxt_far_addr; // R2 R10
    end
  end

  // ----------------------------------------------------------------
  // Channel sequencer
  // ----------------------------------------------------------------
  // Firmware mode moves packets back to back; hardware mode waits for req
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= DC_IDLE;
      bus_ff <= '0;
      aborted_ff <= 1'b0;
    end else begin
      bus_ff.valid <= 1'b0;
      unique case (state_ff)
        DC_IDLE: begin
          if (run && !abort_ff && ((go_ff && hs_dis_ff) || hs_req)) begin // R5 R11
            state_ff <= DC_XFER;
            aborted_ff <= 1'b0;
          end
        end
        DC_XFER: begin
          if (abort_ff || !run) begin
            state_ff <= DC_IDLE; // R4 R11
            aborted_ff <= abort_ff;
          end else if (hs_end) begin
            state_ff <= DC_IDLE; // R9
          end else if (size_ok && (hs_dis_ff || hs_req)) begin // R12
            bus_ff.valid <= 1'b1;
            bus_ff.addr <= far_addr_ff; // R1
            bus_ff.size <= size_ff; // R7
            state_ff <= DC_WAIT;
          end
        end
        DC_WAIT: begin
          if (abort_ff || !run) begin
            state_ff <= DC_IDLE; // R4
            aborted_ff <= abort_ff;
          end else if (pkt_done) begin
            state_ff <= DC_XFER;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd = 32'h0;
    ctrl_rd[dcdac_pkg::POS_ABORT] = abort_ff;
    ctrl_rd[dcdac_pkg::POS_GO] = go_ff;
    ctrl_rd[dcdac_pkg::POS_SIZE_LO +: 3] = size_ff;
    ctrl_rd[dcdac_pkg::POS_HS_DIS] = hs_dis_ff;
    ctrl_rd[dcdac_pkg::POS_INC_FAR] = inc_far_ff;
    ctrl_rd[dcdac_pkg::POS_BUSY] = (state_ff != DC_IDLE);
  end

  // Unmapped offsets read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        dcdac_pkg::OFS_FAR_ADDR: reg_rdata <= far_addr_ff;
        dcdac_pkg::OFS_CONTROL: reg_rdata <= ctrl_rd;
        dcdac_pkg::OFS_CHAN_ACTIVATE: reg_rdata <= {31'h0, chan_en_ff};
        dcdac_pkg::OFS_ENGINE: reg_rdata <= {31'h0, engine_en_ff};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_ff != DC_IDLE);
    end
  end
  assign far_bus = bus_ff;
  assign aborted = aborted_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_issue;
    bus_ff.valid;
  endsequence
  // Each packet carries the address register as it stood when issued
  property p_addr_src;
    @(posedge ref_clk) disable iff (rst) $rose(bus_ff.valid) |-> bus_ff.addr == $past(far_addr_ff);
  endproperty
  a_addr_src: assert property (p_addr_src) else $error("far address not used"); // R1
  // With stepping on, a completed packet steps the address unless software writes it
  property p_step;
    @(posedge ref_clk) disable iff (rst)
      (state_ff == DC_WAIT && pkt_done && inc_far_ff && !reg_wr) |=> far_addr_ff == $past(nxt_far_addr);
  endproperty
  a_step: assert property (p_step) else $error("far address not stepped"); // R2
  // Without stepping the address moves only by a software write
  property p_hold;
    @(posedge ref_clk) disable iff (rst) (!inc_far_ff && !reg_wr) |=> $stable(far_addr_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("far address moved without stepping"); // R10
  property p_width;
    @(posedge ref_clk) disable iff (rst) (far_addr_ff & ~ADDR_MASK) == 32'h0;
  endproperty
  a_width: assert property (p_width) else $error("reserved address bits set"); // R3
  // Abort wins over every other exit of a running transfer
  property p_abort;
    @(posedge ref_clk) disable iff (rst) (abort_ff && state_ff != DC_IDLE) |=> state_ff == DC_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not end transfer"); // R4
  property p_go;
    @(posedge ref_clk) disable iff (rst)
      (state_ff == DC_IDLE && run && !abort_ff && go_ff && hs_dis_ff) |=> state_ff == DC_XFER;
  endproperty
  a_go: assert property (p_go) else $error("go did not start transfer"); // R5
  property p_size;
    @(posedge ref_clk) disable iff (rst) s_issue |-> size_legal(bus_ff.size);
  endproperty
  a_size: assert property (p_size) else $error("illegal packet width issued"); // R7
  property p_ign;
    @(posedge ref_clk) disable iff (rst) (state_ff == DC_IDLE && hs_dis_ff && !go_ff) |=> state_ff == DC_IDLE;
  endproperty
  a_ign: assert property (p_ign) else $error("handshake not ignored"); // R9
  // Dropping either enable parks the sequencer on the next edge
  property p_run;
    @(posedge ref_clk) disable iff (rst) !run |=> state_ff == DC_IDLE;
  endproperty
  a_run: assert property (p_run) else $error("channel ran while disabled"); // R11
  property p_illegal;
    @(posedge ref_clk) disable iff (rst) !size_ok |=> !bus_ff.valid;
  endproperty
  a_illegal: assert property (p_illegal) else $error("transfer with illegal size"); // R12
  // Terminate or done while the handshake is off must not end a running transfer
  property p_ign_end;
    @(posedge ref_clk) disable iff (rst)
      (state_ff != DC_IDLE && hs_dis_ff && run && !abort_ff) |=> state_ff != DC_IDLE;
  endproperty
  a_ign_end: assert property (p_ign_end) else $error("handshake end not ignored"); // R9
  // A synchronised terminate or done ends the transfer at its next decision point
  sequence s_hw_end;
    state_ff == DC_XFER && !hs_dis_ff && (hs_s2_ff.term || hs_s2_ff.done);
  endsequence
  property p_hw_end;
    @(posedge ref_clk) disable iff (rst) s_hw_end |=> state_ff == DC_IDLE;
  endproperty
  a_hw_end: assert property (p_hw_end) else $error("handshake end did not stop transfer"); // R9
  // Read data stand only in the cycle after the strobe, zero otherwise
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (rst) !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule : dcdac_channel
`default_nettype wire

// ### dcdac_flow_master.sv
// Flow-control master model on the far side of one DMA channel.
// Assumes the channel issues one far-side packet at a time.
`timescale 1ns/1ps
`default_nettype none
module dcdac_flow_master (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Packet request from the channel
  input wire dcdac_pkg::dcdac_bus_t far_bus,
  output logic pkt_done,
  // Levels commanded by the bench
  input wire logic req_lvl,
  input wire logic term_lvl,
  input wire logic done_lvl,
  input wire logic [3:0] lag,
  output dcdac_pkg::dcdac_hs_t hs_in
);
  // ----------------------------------------------------------------
  // Packet completion
  // ----------------------------------------------------------------
  logic pend_ff; // A packet is in flight
  logic [3:0] cnt_ff; // Cycles left before completion
  // Handshake levels are plain levels; the channel synchronises them
  assign hs_in = '{req: req_lvl, term: term_lvl, done: done_lvl};
  // Finish each packet after a lag, so both prompt and slow answers occur
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      cnt_ff <= 4'h0;
      pkt_done <= 1'b0;
    end else begin
      pkt_done <= 1'b0;
      if (far_bus.valid) begin
        pend_ff <= 1'b1;
        cnt_ff <= lag;
      end else if (pend_ff && cnt_ff == 4'h0) begin
        pkt_done <= 1'b1;
        pend_ff <= 1'b0;
      end else if (pend_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule : dcdac_flow_master
`default_nettype wire

// ### dcdac_pkg.sv
// Package for the DMA channel far-side address and control block.
// Assumes a 32-bit register port with one-cycle read latency.
`default_nettype none
package dcdac_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHAN_ACTIVATE = 8'h00; // Channel enable
  localparam logic [7:0] OFS_FAR_ADDR = 8'h0c;      // Far-side address
  localparam logic [7:0] OFS_CONTROL = 8'h10;       // Channel control
  localparam logic [7:0] OFS_ENGINE = 8'h20;        // Engine activate bit
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int POS_ABORT = 25;
  localparam int POS_GO = 24;
  localparam int POS_SIZE_LO = 20;
  localparam int POS_HS_DIS = 19;
  localparam int POS_INC_FAR = 17;
  localparam int POS_BUSY = 5;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_FAR_ADDR = 32'h0000_0000;
  localparam logic [2:0] RST_SIZE = 3'h0;
  localparam logic [7:0] RST_COUNT = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Handshake from the selected peripheral flow-control master
  typedef struct packed {
    logic req;
    logic term;
    logic done;
  } dcdac_hs_t;
  // Far-side bus request issued by the channel
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [2:0] size;
  } dcdac_bus_t;
endpackage : dcdac_pkg
`default_nettype wire

// ### tb_dcdac_channel.sv
// Self-checking bench for the far-side address and control block.
// Assumes the flow-control master model and a 24-bit bus address.
`timescale 1ns/1ps
`default_nettype none
module tb_dcdac_channel;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  dcdac_pkg::dcdac_hs_t hs_in;
  dcdac_pkg::dcdac_bus_t far_bus;
  logic pkt_done;
  logic busy;
  logic aborted;
  logic req_lvl = 1'b0;
  logic term_lvl = 1'b0;
  logic done_lvl = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [31:0] rd_val;
  int bad_count = 0;
  int checked = 0;
  int n_pkt = 0; // Packets seen on the far side
  localparam logic [31:0] HS_DIS = 32'h0008_0000;
  localparam logic [31:0] STEP = 32'h0002_0000;
  localparam logic [31:0] GO = 32'h0100_0000;
  localparam logic [31:0] ABORT = 32'h0200_0000;
  // Clock at 50 MHz
  always #10 ref_clk = ~ref_clk;
  dcdac_channel #(.ADDR_W(24)) uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hs_in(hs_in), .far_bus(far_bus), .pkt_done(pkt_done), .busy(busy), .aborted(aborted));
  dcdac_flow_master partner (.ref_clk(ref_clk), .rst(rst), .far_bus(far_bus), .pkt_done(pkt_done),
    .req_lvl(req_lvl), .term_lvl(term_lvl), .done_lvl(done_lvl), .lag(lag), .hs_in(hs_in));
  // Count packets so silent phases can be checked
  always @(posedge ref_clk) if (far_bus.valid === 1'b1) n_pkt++;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic quiet();
    int n0;
    n0 = n_pkt;
    repeat (12) @(posedge ref_clk);
    chk("packets", n_pkt, n0);
  endtask : quiet
  // Wait a bounded time for the next packet and check it
  task automatic pkt(logic [31:0] a, logic [2:0] s);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 20 && far_bus.valid !== 1'b1; i++) @(negedge ref_clk);
    // A missing packet must not pass on stale address and size
    chk("far_valid", {31'h0, far_bus.valid}, 32'h1);
    chk("far_addr", far_bus.addr, a);
    chk("far_size", {29'h0, far_bus.size}, {29'h0, s});
    @(negedge ref_clk);
  endtask : pkt
  task automatic idle();
    int i;
    for (i = 0; i < 12 && busy !== 1'b0; i++) @(negedge ref_clk);
    chk("busy", {31'h0, busy}, 32'h0);
  endtask : idle
  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] s;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h0c);
    chk("far_reset", rd_val, 32'h0);
    rd(8'h10);
    chk("ctrl_reset", rd_val, 32'h0);
    wr(8'h0c, 32'hdead_beef);
    rd(8'h0c);
    chk("far_mask", rd_val, 32'h00ad_beef);
    @(posedge ref_clk);
    #1 chk("rdata_clear", reg_rdata, 32'h0);
    rd(8'h04);
    chk("unmapped", rd_val, 32'h0);
    // Channel enabled but engine off: no transfer may start
    wr(8'h00, 32'h1);
    wr(8'h10, HS_DIS);
    wr(8'h10, HS_DIS | GO | 32'h0040_0000);
    quiet();
    chk("busy_off", {31'h0, busy}, 32'h0);
    wr(8'h10, HS_DIS);
    wr(8'h20, 32'h1);
    // Firmware runs with stepping, every legal size, slow and prompt
    for (int k = 0; k < 3; k++) begin
      s = 32'h1 << k;
      wr(8'h0c, 32'h100);
      lag <= 4'(k);
      wr(8'h10, HS_DIS | STEP | GO | (s << 20));
      for (int j = 0; j < 3; j++) pkt(32'h100 + j * s, s[2:0]);
      wr(8'h10, HS_DIS | ABORT);
      idle();
      chk("aborted", {31'h0, aborted}, 32'h1);
    end
    // Stepping off keeps the address; terminate and done are ignored meanwhile
    wr(8'h0c, 32'h100);
    term_lvl <= 1'b1;
    done_lvl <= 1'b1;
    wr(8'h10, HS_DIS | GO | 32'h0020_0000);
    pkt(32'h100, 3'h2);
    pkt(32'h100, 3'h2);
    wr(8'h10, HS_DIS | ABORT);
    term_lvl <= 1'b0;
    done_lvl <= 1'b0;
    idle();
    // Illegal size issues nothing
    wr(8'h10, HS_DIS | GO | 32'h0030_0000);
    quiet();
    // Still busy, go consumed, size and disable read back
    rd(8'h10);
    chk("ctrl_read", rd_val, 32'h0038_0020);
    wr(8'h10, HS_DIS | ABORT);
    idle();
    // Handshake ignored while disabled, then honoured
    wr(8'h0c, 32'h200);
    wr(8'h10, HS_DIS | 32'h0010_0000);
    req_lvl <= 1'b1;
    quiet();
    wr(8'h10, 32'h0010_0000);
    pkt(32'h200, 3'h1);
    chk("abort_clear", {31'h0, aborted}, 32'h0);
    // Terminate ends the transfer; request drops so it cannot restart
    @(posedge ref_clk);
    req_lvl <= 1'b0;
    term_lvl <= 1'b1;
    idle();
    chk("aborted_term", {31'h0, aborted}, 32'h0);
    // A fresh request starts again, then done ends it
    @(posedge ref_clk);
    term_lvl <= 1'b0;
    req_lvl <= 1'b1;
    pkt(32'h200, 3'h1);
    @(posedge ref_clk);
    req_lvl <= 1'b0;
    done_lvl <= 1'b1;
    idle();
    chk("aborted_done", {31'h0, aborted}, 32'h0);
    @(posedge ref_clk);
    done_lvl <= 1'b0;
    complete_run();
  end
endmodule : tb_dcdac_channel
`default_nettype wire
